//--- dv/sss_master_model.sv
/* spi master model: drives clock, select and data toward the slave.
   assumes the bench calls xfer for one byte per select window. */
`timescale 1ns/1ps
module sss_master_model (
  input  wire logic miso,
  output logic      sclk,
  output logic      mosi,
  output logic      cs_n
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    cs_n = 1'b1;
  end
  // clock stands still outside the frame; 400 ns half period stays legal
  task automatic xfer(input logic pol, input logic pha, input logic lsb,
                      input logic [7:0] d, output logic [7:0] q);
    int k;
    sclk = pol;
    cs_n = 1'b0; // select before any clock edge
    #800;
    for (int i = 0; i < 8; i++) begin
      k = lsb ? i : 7 - i;
      if (!pha) mosi = d[k];
      #400 sclk = ~pol;
      if (!pha) q[k] = miso; else mosi = d[k];
      #400 sclk = pol;
      if (pha) q[k] = miso;
    end
    #800 cs_n = 1'b1;
    mosi = ~mosi; // released line shows no stale bit
    #800;
  endtask : xfer
endmodule : sss_master_model

//--- dv/sss_spi_slave_tb.sv
/* bench for the spi slave: all frame formats, fill, underrun, overflow,
   saved count. assumes the master model drives the link pins. */
`timescale 1ns/1ps
module sss_spi_slave_tb;
  logic core_clk, rst_n, sclk_pin, mosi_pin, chip_select_low, miso_out, miso_oe;
  logic [1:0] controller_mode_reg, rx_buffer_active_ab, tx_buffer_active_ab;
  logic master_select_bit, clock_polarity_bit, clock_phase_bit, bit_order_bit;
  logic repeat_or_busy_select, irq_edge_level_mode, tx_valid, tx_ready, rx_valid, rx_ready;
  logic rx_valid_flag, rx_overflow_flag, tx_idle_flag, tx_free_flag, rx_overflow_clear;
  logic rx_dma_enable, rx_dma_load, dma_channel_reset_bits, rx_dma_error;
  logic top_level_enable, top_level_serial_irq;
  logic [7:0] tx_data, rx_data, q, p, mo;
  logic [7:0] sent [4];
  logic [15:0] rx_dma_count_a, rx_dma_count_b, saved_rx_count_reg, cnt;
  logic [2:0] select_edge_record_field;
  logic [8:0] irq_config_reg, irq_flag_clear, irq_flag_reg;
  logic [31:0] seed = 32'h0000_5803;
  int mismatches = 0, checks = 0;
  sss_spi_slave u_dut (.core_clk, .rst_n, .sclk_pin, .mosi_pin, .chip_select_low, .miso_out,
    .miso_oe, .controller_mode_reg, .master_select_bit, .clock_polarity_bit, .clock_phase_bit,
    .bit_order_bit, .repeat_or_busy_select, .irq_edge_level_mode, .tx_data, .tx_valid,
    .tx_ready, .rx_data, .rx_valid, .rx_ready, .rx_valid_flag, .rx_overflow_flag, .tx_idle_flag,
    .tx_free_flag, .rx_overflow_clear, .rx_dma_enable, .rx_dma_load, .dma_channel_reset_bits,
    .rx_buffer_active_ab, .tx_buffer_active_ab, .rx_dma_count_a, .rx_dma_count_b, .rx_dma_error,
    .saved_rx_count_reg, .select_edge_record_field, .irq_config_reg, .top_level_enable,
    .irq_flag_clear, .irq_flag_reg, .top_level_serial_irq);
  sss_master_model u_master (.miso(miso_out), .sclk(sclk_pin), .mosi(mosi_pin),
    .cs_n(chip_select_low));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // fill character sent when the transmit fifo has nothing
  function automatic logic [7:0] fill(input logic rpt, input logic [7:0] last);
    return rpt ? last : sss_pkg::SSS_BUSY_TOKEN;
  endfunction : fill
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // handshake tasks: bounded wait on ready or valid, one transfer each
  task automatic push(input logic [7:0] d);
    for (int n = 0; tx_ready !== 1'b1; n++) begin
      @(negedge core_clk);
      if (n > 50) begin
        mismatches++;
        give_verdict();
      end
    end
    tx_data = d;
    tx_valid = 1'b1;
    @(negedge core_clk) tx_valid = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : push
  task automatic pop();
    for (int n = 0; rx_valid !== 1'b1; n++) begin
      @(negedge core_clk);
      if (n > 50) begin
        mismatches++;
        give_verdict();
      end
    end
    p = rx_data;
    rx_ready = 1'b1;
    @(negedge core_clk) rx_ready = 1'b0;
    @(negedge core_clk);
  endtask : pop
  task automatic frame(input logic [7:0] m);
    u_master.xfer(clock_polarity_bit, clock_phase_bit, bit_order_bit, m, q);
    @(negedge core_clk);
  endtask : frame
  initial begin
    #2ms mismatches++;
    give_verdict();
  end
  initial begin
    {rst_n, tx_valid, rx_ready, rx_overflow_clear, rx_dma_load, dma_channel_reset_bits} = '0;
    {master_select_bit, clock_polarity_bit, clock_phase_bit, bit_order_bit} = '0;
    {repeat_or_busy_select, irq_edge_level_mode, rx_dma_enable, tx_data} = '0;
    {rx_buffer_active_ab, tx_buffer_active_ab, irq_flag_clear} = '0;
    {rx_dma_count_a, rx_dma_count_b} = '0;
    controller_mode_reg = sss_pkg::SSS_MODE_SPI;
    irq_config_reg = '1;
    top_level_enable = 1'b1;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check("tx_free", tx_free_flag, 1'b1);
    for (int f = 0; f < 8; f++) begin
      {bit_order_bit, clock_phase_bit, clock_polarity_bit} = f[2:0];
      sent[0] = rnd();
      push(sent[0]);
      check("tx_idle", tx_idle_flag, 1'b0);
      mo = rnd();
      frame(mo);
      check("miso", q, sent[0]);
      check("tx_idle", tx_idle_flag, 1'b1);
      check("rx_valid", rx_valid_flag, 1'b1);
      pop();
      check("mosi", p, mo);
    end
    {bit_order_bit, clock_phase_bit, clock_polarity_bit} = '0;
    rx_dma_enable = 1'b1;
    rx_buffer_active_ab = 2'h1;
    cnt = {rnd(), rnd()};
    rx_dma_count_a = cnt;
    rx_dma_load = 1'b1;
    @(negedge core_clk) rx_dma_load = 1'b0;
    for (int i = 0; i < 4; i++) begin
      sent[i] = rnd();
      push(sent[i]);
    end
    check("tx_ready", tx_ready, 1'b0);
    check("tx_free", tx_free_flag, 1'b0);
    for (int i = 0; i < 4; i++) begin
      frame(rnd());
      rx_dma_count_a = ~cnt;
      check("miso", q, sent[i]);
      check("tx_free", tx_free_flag, 1'b1);
    end
    check("saved", saved_rx_count_reg, cnt);
    check("record", select_edge_record_field, 3'h5);
    repeat_or_busy_select = 1'b1;
    frame(rnd());
    check("miso", q, fill(1'b1, sent[3]));
    repeat_or_busy_select = 1'b0;
    frame(rnd());
    check("miso", q, fill(1'b0, sent[3]));
    check("overflow", rx_overflow_flag, 1'b1);
    check("underrun", irq_flag_reg[sss_pkg::SSS_IRQ_TXUND], 1'b1);
    check("irq", top_level_serial_irq, 1'b1);
    check("dma_err", rx_dma_error, 1'b0);
    repeat (4) pop();
    controller_mode_reg = 2'h0;
    frame(rnd());
    check("rx_valid", rx_valid_flag, 1'b0);
    check("dma_err", rx_dma_error, 1'b1);
    dma_channel_reset_bits = 1'b1;
    @(negedge core_clk) dma_channel_reset_bits = 1'b0;
    check("dma_err", rx_dma_error, 1'b0);
    give_verdict();
  end
endmodule : sss_spi_slave_tb

//--- inc/sss_pkg.sv
/*
 * constants, field positions and state types for the spi slave controller.
 * assumes one 10 mhz core clock; all pins are synchronised inside the block.
 */
package sss_pkg;
  // mode value that selects spi operation
  localparam logic [1:0] SSS_MODE_SPI      = 2'h2;
  // character width
  localparam int         SSS_CHAR_W        = 8;
  // fifo depth for both directions
  localparam int         SSS_FIFO_DEPTH    = 4;
  // busy token sent on underrun or padding when repeat is off
  localparam logic [7:0] SSS_BUSY_TOKEN    = 8'hFF;
  // reset value of the last transmitted character
  localparam logic [7:0] SSS_LAST_RESET    = 8'h00;
  // link limit and core rate, used to bound link edge spacing
  localparam int         SSS_LINK_MAX_KBPS = 5000;
  localparam int         SSS_CORE_KHZ      = 10000;
  // least core cycles between two link edges of one polarity
  localparam int         SSS_LINK_MIN_CYC  = SSS_CORE_KHZ / SSS_LINK_MAX_KBPS;
  // saved-count status field codes
  localparam logic [2:0] SSS_SAVE_NONE     = 3'h0;
  localparam logic [2:0] SSS_SAVE_A        = 3'h1;
  localparam logic [2:0] SSS_SAVE_B        = 3'h2;
  localparam int         SSS_SAVE_EXTRA_B  = 2;
  // irq flag vector positions
  localparam int         SSS_IRQ_RXVAL     = 0;
  localparam int         SSS_IRQ_TXFREE    = 1;
  localparam int         SSS_IRQ_TXIDLE    = 2;
  localparam int         SSS_IRQ_RXOVR     = 3;
  localparam int         SSS_IRQ_TXUND     = 4;
  localparam int         SSS_IRQ_TXDMA_A   = 5;
  localparam int         SSS_IRQ_TXDMA_B   = 6;
  localparam int         SSS_IRQ_RXDMA_A   = 7;
  localparam int         SSS_IRQ_RXDMA_B   = 8;
  localparam int         SSS_IRQ_W         = 9;
  // frame engine states, gray along idle -> selected -> shifting
  typedef enum logic [1:0] {
    SSS_IDLE  = 2'b00,
    SSS_SEL   = 2'b01,
    SSS_SHIFT = 2'b11
  } sss_state_t;
endpackage : sss_pkg

//--- verilog/sss_fifo.sv
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module sss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];      // storage
  logic [AW-1:0]    wr_ptr_reg;       // write index
  logic [AW-1:0]    rd_ptr_reg;       // read index
  logic [AW:0]      cnt_reg;          // occupancy
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign count     = cnt_reg;

  // storage write, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and count; flush empties the fifo
  always_ff @(posedge core_clk) begin
    if (!rst_n || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
      if (pop)  rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sss_fifo

//--- verilog/sss_spi_slave.sv
/*
 * spi slave controller: link sampling, shift engine, fifos, status,
 * padding, saved receive count and second-level interrupt flags.
 * assumes the master drives sclk/mosi/select from outside this clock domain;
 * link edges are found by oversampling with the 10 mhz core clock.
 */
// Overview of operation
// - active only for mode two, master bit zero
// - link rate up to 5 Mbps
// - polarity, phase and bit order all supported
// - drive miso, sample mosi only while selected
// - select falling edge clears the receive shift register and loads the transmit one
// - four-entry transmit and receive fifos
// - data port and dma share fifos
// - stored character sets receive valid
// - full receive fifo drops, flags overflow, irq
// - dma overrun shown after drain, cleared later
// - each received char shifts out one tx char
// - empty tx: underrun, repeat last or ff
// - tx idle clears on write, sets after drain
// - tx free clears when full, sets on shift
// - pad byte ahead of each new tx run
// - padding armed after select and rx valid
// - pad value chosen by repeat bit
// - select rise copies active rx dma count
// - only first rise after load saves count
// - three-bit field records save and extra rise
// - level events edge or level per irq mode
// - overrun, underrun, dma completion also flag
`timescale 1ns/1ps
module sss_spi_slave #(
  parameter int CHAR_W  = sss_pkg::SSS_CHAR_W,
  parameter int DEPTH   = sss_pkg::SSS_FIFO_DEPTH,
  parameter int CNT_W   = 16
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // link pins
  input  wire logic                 sclk_pin,
  input  wire logic                 mosi_pin,
  input  wire logic                 chip_select_low,
  output logic                      miso_out,
  output logic                      miso_oe,
  // configuration
  input  wire logic [1:0]           controller_mode_reg,
  input  wire logic                 master_select_bit,
  input  wire logic                 clock_polarity_bit,
  input  wire logic                 clock_phase_bit,
  input  wire logic                 bit_order_bit,
  input  wire logic                 repeat_or_busy_select,
  input  wire logic                 irq_edge_level_mode,
  // transmit push (data port or dma)
  input  wire logic [CHAR_W-1:0]    tx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  // receive pop (data port or dma)
  output logic [CHAR_W-1:0]         rx_data,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  // status
  output logic                      rx_valid_flag,
  output logic                      rx_overflow_flag,
  output logic                      tx_idle_flag,
  output logic                      tx_free_flag,
  input  wire logic                 rx_overflow_clear,
  // dma side
  input  wire logic                 rx_dma_enable,
  input  wire logic                 rx_dma_load,
  input  wire logic                 dma_channel_reset_bits,
  input  wire logic [1:0]           rx_buffer_active_ab,
  input  wire logic [1:0]           tx_buffer_active_ab,
  input  wire logic [CNT_W-1:0]     rx_dma_count_a,
  input  wire logic [CNT_W-1:0]     rx_dma_count_b,
  output logic                      rx_dma_error,
  output logic [CNT_W-1:0]          saved_rx_count_reg,
  output logic [2:0]                select_edge_record_field,
  // second-level interrupts
  input  wire logic [sss_pkg::SSS_IRQ_W-1:0] irq_config_reg,
  input  wire logic                 top_level_enable,
  input  wire logic [sss_pkg::SSS_IRQ_W-1:0] irq_flag_clear,
  output logic [sss_pkg::SSS_IRQ_W-1:0]      irq_flag_reg,
  output logic                      top_level_serial_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops, second one is the only reader of the first
  // limitation: edges show two core cycles late; at the 5 Mbps top rate a
  // half bit is one core cycle, so there is no margin left
  logic [2:0] sync1_reg;                // first stage
  logic [2:0] sync2_reg;                // second stage
  logic [2:0] last_reg;                 // previous synced value for edges
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
      last_reg  <= 3'h7;
    end else begin
      sync1_reg <= {chip_select_low, mosi_pin, sclk_pin};
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  logic enabled;      // spi slave mode active
  logic sel;          // select asserted (low at the pin)
  logic sel_fall;     // select just asserted
  logic sel_rise;     // select just released
  logic sck_rise;
  logic sck_fall;
  logic lead_edge;    // first edge of a bit period given polarity
  logic sample_edge;  // edge on which mosi is captured
  logic shift_edge;   // edge on which next miso bit is driven
  assign enabled  = (controller_mode_reg == sss_pkg::SSS_MODE_SPI)
                    && !master_select_bit;
  assign sel      = !sync2_reg[2] && enabled;
  assign sel_fall = last_reg[2] && !sync2_reg[2] && enabled;
  assign sel_rise = !last_reg[2] && sync2_reg[2] && enabled;
  assign sck_rise = !last_reg[0] && sync2_reg[0];
  assign sck_fall = last_reg[0] && !sync2_reg[0];
  // leading edge is rising for idle-low clock, falling for idle-high
  assign lead_edge   = clock_polarity_bit ? sck_fall : sck_rise;
  // phase 0 samples on leading edge, phase 1 on trailing edge
  assign sample_edge = sel && (clock_phase_bit ? !lead_edge && (sck_rise || sck_fall)
                                               : lead_edge);
  assign shift_edge  = sel && (clock_phase_bit ? lead_edge
                                               : !lead_edge && (sck_rise || sck_fall));

  ////////////////////////////////////////////////////////////////////////////
  // fifos: both four deep, shared by data port and dma
  logic [CHAR_W-1:0] txf_data;
  logic              txf_valid;
  logic              txf_pop;
  logic [$clog2(DEPTH):0] txf_count;
  logic [CHAR_W-1:0] rxf_in;
  logic              rxf_push;
  logic              rxf_in_ready;
  logic [$clog2(DEPTH):0] rxf_count;

  sss_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_tx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .flush     (1'b0),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (txf_data),
    .out_valid (txf_valid),
    .out_ready (txf_pop),
    .count     (txf_count)
  );
  sss_fifo #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_rx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .flush     (1'b0),
    .in_data   (rxf_in),
    .in_valid  (rxf_push),
    .in_ready  (rxf_in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .count     (rxf_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame state
  sss_pkg::sss_state_t state_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= sss_pkg::SSS_IDLE;
    end else begin
      unique case (state_reg)
        sss_pkg::SSS_IDLE:  if (sel) state_reg <= sss_pkg::SSS_SEL;
        sss_pkg::SSS_SEL:   if (!sel) state_reg <= sss_pkg::SSS_IDLE;
                            else if (sck_rise || sck_fall) state_reg <= sss_pkg::SSS_SHIFT;
        sss_pkg::SSS_SHIFT: if (!sel) state_reg <= sss_pkg::SSS_IDLE;
        default:            state_reg <= sss_pkg::SSS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift engine
  logic [CHAR_W-1:0] rx_sh_reg;     // receive shift register
  logic [CHAR_W-1:0] tx_sh_reg;     // transmit shift register
  logic [3:0]        bit_cnt_reg;   // bits sampled in current char
  logic [CHAR_W-1:0] last_tx_reg;   // last character loaded for repeat
  logic              tx_loaded_reg; // serializer holds a real char
  logic              pad_arm_reg;   // padding armed this selection
  logic              pad_pend_reg;  // pad byte goes out before next fifo char
  logic              char_done;     // a whole char was just sampled
  logic [CHAR_W-1:0] rx_next;
  logic [CHAR_W-1:0] fill_char;     // underrun / padding value
  logic              load_next;     // load serializer for the next char
  logic              tx_underrun;
  logic              tx_fresh_reg;  // next shift edge belongs to the load
  logic              reload_tx;     // restart an unsent char at select fall
  assign rx_next   = bit_order_bit ? {sync2_reg[1], rx_sh_reg[CHAR_W-1:1]}
                                   : {rx_sh_reg[CHAR_W-2:0], sync2_reg[1]};
  // a select fall in the same cycle wins, so a cut char is never stored
  assign char_done = sample_edge && !sel_fall && (bit_cnt_reg == 4'(CHAR_W-1));
  // same repeat bit picks underrun and padding value
  assign fill_char = repeat_or_busy_select ? last_tx_reg : sss_pkg::SSS_BUSY_TOKEN;
  // a char popped before the last select rise is resent, not lost
  assign reload_tx   = sel_fall && tx_loaded_reg;
  // every received char and every select fall that does not reload pull the next one
  assign load_next   = (char_done || sel_fall) && !reload_tx;
  assign txf_pop     = load_next && txf_valid && !pad_pend_reg;
  assign tx_underrun = load_next && !txf_valid;

  // receive shifting, cleared at select fall
  always_ff @(posedge core_clk) begin
    if (!rst_n || sel_fall) begin
      rx_sh_reg   <= '0;
      bit_cnt_reg <= '0;
    end else if (sample_edge) begin
      rx_sh_reg   <= rx_next;
      bit_cnt_reg <= char_done ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end

  // transmit loading and shifting; the first shift edge after a load, except a phase 0
  // load at select fall, belongs to that load, so it leaves the register as it is
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_sh_reg     <= '0;
      last_tx_reg   <= sss_pkg::SSS_LAST_RESET;
      tx_loaded_reg <= 1'b0;
      tx_fresh_reg  <= 1'b0;
    end else if (reload_tx) begin
      tx_sh_reg     <= last_tx_reg;
      tx_fresh_reg  <= clock_phase_bit;
    end else if (load_next) begin
      // phase 0 shows bit one at select fall already
      tx_fresh_reg  <= clock_phase_bit || !sel_fall;
      if (txf_pop) begin
        tx_sh_reg     <= txf_data;
        last_tx_reg   <= txf_data;
        tx_loaded_reg <= 1'b1;
      end else begin
        tx_sh_reg     <= fill_char;
        tx_loaded_reg <= 1'b0;
      end
    end else if (shift_edge) begin
      tx_fresh_reg <= 1'b0;
      if (!tx_fresh_reg) begin
        tx_sh_reg <= bit_order_bit ? {1'b0, tx_sh_reg[CHAR_W-1:1]}
                                   : {tx_sh_reg[CHAR_W-2:0], 1'b0};
      end
    end
  end

  // miso drives only while selected
  assign miso_oe  = sel;
  assign miso_out = sel && (bit_order_bit ? tx_sh_reg[0] : tx_sh_reg[CHAR_W-1]);

  // padding armed by select plus rx valid, pending on an empty-fifo push
  always_ff @(posedge core_clk) begin
    if (!rst_n || !sel) begin
      pad_arm_reg  <= 1'b0;
      pad_pend_reg <= 1'b0;
    end else begin
      if (rx_valid_flag) pad_arm_reg <= 1'b1;
      if (pad_arm_reg && tx_valid && tx_ready && !txf_valid)
        pad_pend_reg <= 1'b1;
      else if (load_next)
        pad_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive store and overflow
  logic rx_drop;
  assign rxf_in   = rx_next;
  assign rxf_push = char_done;
  assign rx_drop  = char_done && !rxf_in_ready;
  assign rx_valid_flag = rx_valid;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_overflow_flag <= 1'b0;
    end else if (rx_drop) begin
      rx_overflow_flag <= 1'b1;
    end else if (rx_overflow_clear) begin
      rx_overflow_flag <= 1'b0;
    end
  end

  // dma error waits for drain; cleared by reset bit or reload
  logic rx_err_pend_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_err_pend_reg <= 1'b0;
      rx_dma_error    <= 1'b0;
    end else begin
      if (rx_drop) rx_err_pend_reg <= 1'b1;
      else if (rx_err_pend_reg && !rx_valid) rx_err_pend_reg <= 1'b0;
      if (rx_err_pend_reg && !rx_valid) rx_dma_error <= 1'b1;
      else if (dma_channel_reset_bits || rx_dma_load) rx_dma_error <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tx status flags
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_idle_flag <= 1'b1;
      tx_free_flag <= 1'b1;
    end else begin
      if (tx_valid && tx_ready)
        tx_idle_flag <= 1'b0;
      else if (!txf_valid && !tx_loaded_reg)
        tx_idle_flag <= 1'b1;
      if (txf_pop)
        tx_free_flag <= 1'b1;
      else if (tx_valid && tx_ready && txf_count == ($clog2(DEPTH)+1)'(DEPTH-1))
        tx_free_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // saved receive count on select rise
  logic save_armed_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      saved_rx_count_reg       <= '0;
      select_edge_record_field <= sss_pkg::SSS_SAVE_NONE;
      save_armed_reg           <= 1'b0;
    end else if (rx_dma_load) begin
      save_armed_reg           <= 1'b1;
      select_edge_record_field <= sss_pkg::SSS_SAVE_NONE;
    end else if (sel_rise && rx_dma_enable) begin
      if (save_armed_reg) begin
        save_armed_reg <= 1'b0;
        saved_rx_count_reg <= rx_buffer_active_ab[0] ? rx_dma_count_a : rx_dma_count_b;
        select_edge_record_field <= rx_buffer_active_ab[0] ? sss_pkg::SSS_SAVE_A
                                                          : sss_pkg::SSS_SAVE_B;
      end else begin
        select_edge_record_field[sss_pkg::SSS_SAVE_EXTRA_B] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second-level interrupt events
  logic [2:0] lvl_last_reg;
  logic [1:0] txact_last_reg;
  logic [1:0] rxact_last_reg;
  logic [sss_pkg::SSS_IRQ_W-1:0] ev;
  logic [2:0] lvl;
  assign lvl = {tx_idle_flag, tx_free_flag, rx_valid_flag};
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lvl_last_reg   <= 3'h6;
      txact_last_reg <= 2'h0;
      rxact_last_reg <= 2'h0;
    end else begin
      lvl_last_reg   <= lvl;
      txact_last_reg <= tx_buffer_active_ab;
      rxact_last_reg <= rx_buffer_active_ab;
    end
  end
  always_comb begin
    ev = '0;
    // level mode or rising transition
    ev[2:0] = irq_edge_level_mode ? lvl : (lvl & ~lvl_last_reg);
    ev[sss_pkg::SSS_IRQ_RXOVR] = rx_drop;
    ev[sss_pkg::SSS_IRQ_TXUND] = tx_underrun && sel;
    ev[6:5] = txact_last_reg & ~tx_buffer_active_ab;
    ev[8:7] = rxact_last_reg & ~rx_buffer_active_ab;
  end
  // sticky flags: set wins over clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) irq_flag_reg <= '0;
    else irq_flag_reg <= ev | (irq_flag_reg & ~irq_flag_clear);
  end
  assign top_level_serial_irq = top_level_enable
                                && |(irq_flag_reg & irq_config_reg);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_MISO_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sel |-> !miso_oe && !miso_out) else $error("miso driven while deselected");
  AST_OVF_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_drop |=> rx_overflow_flag) else $error("overflow not flagged");
  AST_OVR_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_drop |=> irq_flag_reg[sss_pkg::SSS_IRQ_RXOVR]) else $error("overrun irq missing");
  AST_INACTIVE: assert property (@(posedge core_clk) disable iff (!rst_n)
    master_select_bit |-> !miso_oe) else $error("active in master mode");
  AST_RX_FALL_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
    sel_fall |=> bit_cnt_reg == 4'h0) else $error("shift not reset");
  AST_UND_FILL: assert property (@(posedge core_clk) disable iff (!rst_n)
    tx_underrun && !repeat_or_busy_select |=> tx_sh_reg == sss_pkg::SSS_BUSY_TOKEN)
    else $error("busy token not loaded");
  AST_FREE_FULL: assert property (@(posedge core_clk) disable iff (!rst_n)
    txf_count == ($clog2(DEPTH)+1)'(DEPTH) |-> !tx_free_flag)
    else $error("free while full");
  AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !top_level_enable |-> !top_level_serial_irq) else $error("irq without enable");
  AST_RXVAL: assert property (@(posedge core_clk) disable iff (!rst_n)
    rxf_push && rxf_in_ready |=> rx_valid_flag) else $error("rx valid missing");
  AST_SAVE_CODE: assert property (@(posedge core_clk) disable iff (!rst_n)
    sel_rise && rx_dma_enable && save_armed_reg && !rx_dma_load |=>
    select_edge_record_field != sss_pkg::SSS_SAVE_NONE) else $error("save not recorded");
  COV_CHAR: cover property (@(posedge core_clk) disable iff (!rst_n) rxf_push);
  COV_DROP: cover property (@(posedge core_clk) disable iff (!rst_n) rx_drop);
  COV_UND:  cover property (@(posedge core_clk) disable iff (!rst_n) tx_underrun && sel);
  COV_SAVE: cover property (@(posedge core_clk) disable iff (!rst_n) sel_rise && save_armed_reg);
endmodule : sss_spi_slave
